// ### event_timer_channel.sv
// Shared constants and one 8-bit timer/event counter channel
`timescale 1ns/1ps

package timer_pkg;
  // ****************************************
  // Widths
  // ****************************************
  localparam int CNT_WIDTH = 8;
  localparam int PRESC_WIDTH = 12;
  localparam int SEL_WIDTH = 4;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;
  // ****************************************
  // Clock-select encodings
  // ****************************************
  localparam logic [3:0] SEL_EXT_RISE = 4'h0;
  localparam logic [3:0] SEL_EXT_FALL = 4'h1;
  localparam logic [3:0] SEL_INT_FIRST = 4'h6;
  localparam logic [3:0] SEL_INT_TOP = 4'hF;
  localparam logic [3:0] EXP_OFFSET = 4'h5;
  localparam logic [3:0] EXP_TOP = 4'hB;
  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [7:0] ADDR_CLK_SEL = 8'h00;
  localparam logic [7:0] ADDR_OSC_MODE = 8'h04;
  localparam logic [7:0] ADDR_OUT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_CMP_ONE = 8'h0C;
  localparam logic [7:0] ADDR_CMP_TWO = 8'h10;
  localparam logic [7:0] ADDR_CNT_ONE = 8'h14;
  localparam logic [7:0] ADDR_CNT_TWO = 8'h18;
  localparam logic [7:0] ADDR_RUN = 8'h1C;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CS_CH1_LSB = 0;
  localparam int CS_CH2_LSB = 4;
  localparam int OSC_BIT = 0;
  localparam int OC_OE1 = 0;
  localparam int OC_FRST1 = 2;
  localparam int OC_FSET1 = 3;
  localparam int OC_OE2 = 4;
  localparam int OC_FRST2 = 6;
  localparam int OC_FSET2 = 7;
  localparam int RUN_ONE = 0;
  localparam int RUN_TWO = 1;
  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RST_CLK_SEL = 8'h00;
  localparam logic RST_OSC = 1'b0;
  localparam logic [7:0] RST_CMP = 8'hFF;
  localparam logic [1:0] RST_RUN = 2'h0;
  localparam logic RST_OE = 1'b0;
endpackage

module event_timer_channel
  import timer_pkg::*;
#(
  parameter int CNT_W = CNT_WIDTH,
  parameter int PRESC_W = PRESC_WIDTH
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [PRESC_W-1:0] presc,
  input wire logic [SEL_WIDTH-1:0] clk_sel,
  input wire logic osc_mode_bit,
  input wire logic run,
  input wire logic event_pin,
  input wire logic [CNT_W-1:0] compare,
  input wire logic out_enable,
  input wire logic force_set,
  input wire logic force_reset,
  output logic [CNT_W-1:0] count_r,
  output logic irq_r,
  output logic wave_pin_r
);
  logic ev_s1_r;
  logic ev_s2_r;
  logic ev_prev_r;
  logic ext_tick;
  logic int_sel;
  logic int_tick;
  logic tick;
  logic match;
  logic wave_ff_r;
  logic [3:0] exp_w;
  logic [PRESC_W:0] mask_w;

  // ****************************************
  // Event pin synchroniser and edge pick
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ev_s1_r <= 1'b0;
      ev_s2_r <= 1'b0;
      ev_prev_r <= 1'b0;
    end else begin
      ev_s1_r <= event_pin;
      ev_s2_r <= ev_s1_r;
      ev_prev_r <= ev_s2_r;
    end
  end

  // Levels held for less than one pclk period may be missed
  always_comb begin
    ext_tick = 1'b0;
    if (clk_sel == SEL_EXT_RISE) begin
      ext_tick = ev_s2_r & ~ev_prev_r;
    end else if (clk_sel == SEL_EXT_FALL) begin
      ext_tick = ~ev_s2_r & ev_prev_r;
    end
  end

  // ****************************************
  // Prescaler tap choice
  // ****************************************
  always_comb begin
    int_sel = 1'b0;
    exp_w = 4'h1;
    if (clk_sel >= SEL_INT_FIRST) begin
      int_sel = 1'b1;
      exp_w = (clk_sel == SEL_INT_TOP) ? EXP_TOP : clk_sel - EXP_OFFSET;
      if (!osc_mode_bit) begin
        exp_w = exp_w + 4'h1;
      end
    end
  end

  assign mask_w = ({{PRESC_W{1'b0}}, 1'b1} << exp_w) - {{PRESC_W{1'b0}}, 1'b1};
  // Prohibited codes give no tick at all, so the counter holds
  assign int_tick = int_sel && ((presc & mask_w[PRESC_W-1:0]) == mask_w[PRESC_W-1:0]);
  assign tick = run && (int_tick || ext_tick);
  assign match = tick && (count_r == compare);

  // ****************************************
  // Counter and match request
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_r <= '0;
    end else if (!run) begin
      count_r <= '0;
    end else if (match) begin
      count_r <= '0;
    end else if (tick) begin
      count_r <= count_r + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= match;
    end
  end

  // ****************************************
  // Square-wave flip-flop
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_ff_r <= 1'b0;
    end else if (force_set && !force_reset) begin
      wave_ff_r <= 1'b1;
    end else if (force_reset && !force_set) begin
      wave_ff_r <= 1'b0;
    end else if (match && out_enable) begin
      wave_ff_r <= ~wave_ff_r;
    end
  end

  // Port mode drives low when the output is disabled
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_pin_r <= 1'b0;
    end else begin
      wave_pin_r <= wave_ff_r & out_enable;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_clear_on_match;
    @(posedge pclk) disable iff (!presetn) irq_r |-> count_r == '0;
  endproperty
  a_clear_on_match: assert property (p_clear_on_match) else $error("count not zero after match");

  property p_irq_cause;
    @(posedge pclk) disable iff (!presetn) irq_r |-> $past(count_r) == $past(compare) && $past(run);
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq without compare match");

  property p_step;
    @(posedge pclk) disable iff (!presetn)
      (run && $past(run) && $changed(count_r)) |-> (count_r == $past(count_r) + 1'b1) || irq_r;
  endproperty
  a_step: assert property (p_step) else $error("counter moved by other than one");

  property p_advance;
    @(posedge pclk) disable iff (!presetn) (tick && count_r != compare) |=> count_r == $past(count_r) + 1'b1;
  endproperty
  a_advance: assert property (p_advance) else $error("counter missed a tick");

  property p_ext;
    @(posedge pclk) disable iff (!presetn)
      (run && clk_sel == SEL_EXT_RISE && ev_s2_r && !ev_prev_r && count_r != compare) |=> count_r != $past(count_r);
  endproperty
  a_ext: assert property (p_ext) else $error("rising event not counted");

  property p_wave;
    @(posedge pclk) disable iff (!presetn)
      (match && out_enable && !force_set && !force_reset) |=> wave_ff_r != $past(wave_ff_r);
  endproperty
  a_wave: assert property (p_wave) else $error("wave did not toggle on match");

  property p_prohibited;
    @(posedge pclk) disable iff (!presetn)
      (clk_sel > SEL_EXT_FALL && clk_sel < SEL_INT_FIRST) |-> !int_tick && !ext_tick;
  endproperty
  a_prohibited: assert property (p_prohibited) else $error("prohibited code produced a tick");

  property p_fast_tap;
    @(posedge pclk) disable iff (!presetn)
      (int_tick && clk_sel == SEL_INT_FIRST && osc_mode_bit) ##1 (clk_sel == SEL_INT_FIRST && osc_mode_bit)
        ##1 (clk_sel == SEL_INT_FIRST && osc_mode_bit) |-> int_tick && !$past(int_tick);
  endproperty
  a_fast_tap: assert property (p_fast_tap) else $error("finest tap not two cycles");
endmodule

// ### dual_8bit_event_timer.sv
// Two 8-bit timer/event counters with square-wave outputs behind an APB slave
`timescale 1ns/1ps

// Operation
// - Channel two select codes 0000/0001 count pin edges, 0110-1111 prescaled clock.
// - Oscillation mode bit set halves every prescaler divide ratio.
// - Counters are 8 bits, compare 00H-FFH, longest interval 256 count clocks.
// - Each counter counts edges on its own event pin independently.
// - One increment per valid edge; rising or falling chosen by select code.
// - On compare equality the counter clears and its match request fires.
// - With output enable set the wave pin inverts on every match.
// - Internal half period spans 2 to 2^20 main clock periods.
// - After a match clear the counter keeps counting from zero.
// - Select bits 0-3 drive channel one, bits 4-7 channel two.
// - Force-set and force-reset bits are strobes and read back as zero.

module dual_8bit_event_timer
  import timer_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_WIDTH-1:0] paddr,
  input wire logic [DATA_WIDTH-1:0] pwdata,
  output logic [DATA_WIDTH-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_pin_one,
  input wire logic event_pin_two,
  output logic wave_pin_one,
  output logic wave_pin_two,
  output logic match_irq_one,
  output logic match_irq_two
);
  logic [7:0] clock_select_reg_r;
  logic osc_mode_bit_r;
  logic out_enable_one_r;
  logic out_enable_two_r;
  logic [CNT_WIDTH-1:0] compare_one_r;
  logic [CNT_WIDTH-1:0] compare_two_r;
  logic [1:0] run_r;
  logic [PRESC_WIDTH-1:0] presc_r;
  logic [CNT_WIDTH-1:0] counter_one;
  logic [CNT_WIDTH-1:0] counter_two;
  logic [DATA_WIDTH-1:0] rdata_nxt;
  logic [DATA_WIDTH-1:0] prdata_r;
  logic mapped;
  logic wr_access;
  logic oc_write;
  logic force_set_one;
  logic force_reset_one;
  logic force_set_two;
  logic force_reset_two;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero-wait slave: every access completes in its first access cycle
  assign pready = 1'b1;
  always_comb begin
    case (paddr)
      ADDR_CLK_SEL, ADDR_OSC_MODE, ADDR_OUT_CTRL, ADDR_CMP_ONE, ADDR_CMP_TWO, ADDR_CNT_ONE, ADDR_CNT_TWO,
      ADDR_RUN: begin
        mapped = 1'b1;
      end
      default: begin
        mapped = 1'b0;
      end
    endcase
  end
  assign pslverr = psel && penable && !mapped;
  assign wr_access = psel && penable && pwrite && mapped;
  assign oc_write = wr_access && (paddr == ADDR_OUT_CTRL);

  // Strobes live for the write cycle only, never stored
  assign force_set_one = oc_write && pwdata[OC_FSET1];
  assign force_reset_one = oc_write && pwdata[OC_FRST1];
  assign force_set_two = oc_write && pwdata[OC_FSET2];
  assign force_reset_two = oc_write && pwdata[OC_FRST2];

  // ****************************************
  // Configuration registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_select_reg_r <= RST_CLK_SEL;
      osc_mode_bit_r <= RST_OSC;
      compare_one_r <= RST_CMP;
      compare_two_r <= RST_CMP;
      run_r <= RST_RUN;
    end else if (wr_access) begin
      case (paddr)
        ADDR_CLK_SEL: begin
          clock_select_reg_r <= pwdata[7:0];
        end
        ADDR_OSC_MODE: begin
          osc_mode_bit_r <= pwdata[OSC_BIT];
        end
        ADDR_CMP_ONE: begin
          compare_one_r <= pwdata[CNT_WIDTH-1:0];
        end
        ADDR_CMP_TWO: begin
          compare_two_r <= pwdata[CNT_WIDTH-1:0];
        end
        ADDR_RUN: begin
          run_r <= pwdata[1:0];
        end
        default: begin
          run_r <= run_r;
        end
      endcase
    end
  end

  // Output control is not guarded against writes while running
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_enable_one_r <= RST_OE;
      out_enable_two_r <= RST_OE;
    end else if (oc_write) begin
      out_enable_one_r <= pwdata[OC_OE1];
      out_enable_two_r <= pwdata[OC_OE2];
    end
  end

  // ****************************************
  // Shared prescaler
  // ****************************************
  // Free running so both channels see a common phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      presc_r <= '0;
    end else begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // ****************************************
  // Channels
  // ****************************************
  event_timer_channel u_ch_one (
    .pclk(pclk),
    .presetn(presetn),
    .presc(presc_r),
    .clk_sel(clock_select_reg_r[CS_CH1_LSB +: SEL_WIDTH]),
    .osc_mode_bit(osc_mode_bit_r),
    .run(run_r[RUN_ONE]),
    .event_pin(event_pin_one),
    .compare(compare_one_r),
    .out_enable(out_enable_one_r),
    .force_set(force_set_one),
    .force_reset(force_reset_one),
    .count_r(counter_one),
    .irq_r(match_irq_one),
    .wave_pin_r(wave_pin_one)
  );

  event_timer_channel u_ch_two (
    .pclk(pclk),
    .presetn(presetn),
    .presc(presc_r),
    .clk_sel(clock_select_reg_r[CS_CH2_LSB +: SEL_WIDTH]),
    .osc_mode_bit(osc_mode_bit_r),
    .run(run_r[RUN_TWO]),
    .event_pin(event_pin_two),
    .compare(compare_two_r),
    .out_enable(out_enable_two_r),
    .force_set(force_set_two),
    .force_reset(force_reset_two),
    .count_r(counter_two),
    .irq_r(match_irq_two),
    .wave_pin_r(wave_pin_two)
  );

  // ****************************************
  // Read path
  // ****************************************
  always_comb begin
    rdata_nxt = '0;
    case (paddr)
      ADDR_CLK_SEL: begin
        rdata_nxt[7:0] = clock_select_reg_r;
      end
      ADDR_OSC_MODE: begin
        rdata_nxt[OSC_BIT] = osc_mode_bit_r;
      end
      ADDR_OUT_CTRL: begin
        rdata_nxt[OC_OE1] = out_enable_one_r;
        rdata_nxt[OC_OE2] = out_enable_two_r;
      end
      ADDR_CMP_ONE: begin
        rdata_nxt[CNT_WIDTH-1:0] = compare_one_r;
      end
      ADDR_CMP_TWO: begin
        rdata_nxt[CNT_WIDTH-1:0] = compare_two_r;
      end
      ADDR_CNT_ONE: begin
        rdata_nxt[CNT_WIDTH-1:0] = counter_one;
      end
      ADDR_CNT_TWO: begin
        rdata_nxt[CNT_WIDTH-1:0] = counter_two;
      end
      ADDR_RUN: begin
        rdata_nxt[1:0] = run_r;
      end
      default: begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Captured in the setup cycle so prdata is a flop in the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
    end else if (psel && !penable) begin
      prdata_r <= rdata_nxt;
    end
  end
  assign prdata = prdata_r;

  // ****************************************
  // Checks
  // ****************************************
  property p_strobe_read;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable && !pwrite && paddr == ADDR_OUT_CTRL)
        |=> prdata[OC_FSET1] == 1'b0 && prdata[OC_FRST1] == 1'b0 && prdata[OC_FSET2] == 1'b0
            && prdata[OC_FRST2] == 1'b0;
  endproperty
  a_strobe_read: assert property (p_strobe_read) else $error("force strobe read back nonzero");

  property p_sel_write;
    @(posedge pclk) disable iff (!presetn)
      (psel && penable && pwrite && paddr == ADDR_CLK_SEL) |=> clock_select_reg_r == $past(pwdata[7:0]);
  endproperty
  a_sel_write: assert property (p_sel_write) else $error("clock select write lost");

  property p_stopped_clear;
    @(posedge pclk) disable iff (!presetn)
      !run_r[RUN_ONE] ##1 !run_r[RUN_ONE] |-> counter_one == '0 && !match_irq_one;
  endproperty
  a_stopped_clear: assert property (p_stopped_clear) else $error("stopped counter not clear");

  property p_unmapped;
    @(posedge pclk) disable iff (!presetn) (psel && penable && !mapped) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped access not flagged");
endmodule

// ### event_source.sv
// Far-side model: pulse sources on both event pins
`timescale 1ns/1ps
module event_source (
  input wire logic pclk,
  output logic pin_one,
  output logic pin_two
);
  // ****************************************
  // Pulse generation
  // ****************************************
  // Pins idle low; each level is held at least two clocks so the synchroniser sees it
  initial begin
    pin_one = 1'b0;
    pin_two = 1'b0;
  end

  task automatic pulse(input int ch, input int n, input int w);
    for (int i = 0; i < n; i++) begin
      @(posedge pclk);
      if (ch == 1) pin_one <= 1'b1;
      else pin_two <= 1'b1;
      repeat (w) @(posedge pclk);
      if (ch == 1) pin_one <= 1'b0;
      else pin_two <= 1'b0;
      repeat (w) @(posedge pclk);
    end
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the dual event timer
`timescale 1ns/1ps
module tb_top
  import timer_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  logic ev1, ev2, wave1, wave2, irq1, irq2, err_v;
  int n_errors, checks_done, cyc, n_irq1, n_irq2, gap_n, expv;
  logic [7:0] ra [8] = '{ADDR_CLK_SEL, ADDR_OSC_MODE, ADDR_OUT_CTRL, ADDR_CMP_ONE,
                         ADDR_CMP_TWO, ADDR_CNT_ONE, ADDR_CNT_TWO, ADDR_RUN};
  logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'hFF, 32'hFF, 32'h0, 32'h0, 32'h0};

  dual_8bit_event_timer dual_8bit_event_timer_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .event_pin_one(ev1), .event_pin_two(ev2),
    .wave_pin_one(wave1), .wave_pin_two(wave2), .match_irq_one(irq1), .match_irq_two(irq2));
  event_source event_source_i (.pclk(pclk), .pin_one(ev1), .pin_two(ev2));

  // ****************************************
  // Clock, watchdog and match counting
  // ****************************************
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // Ceiling covers the slowest prescaler sweep with a wide margin
  always @(posedge pclk) begin
    cyc++;
    n_irq1 += int'(irq1);
    n_irq2 += int'(irq2);
    if (cyc == 100000) begin
      n_errors++;
      tally_and_finish;
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r,
           output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ends on the first edge with pready high; the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd_v, err_v);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rd_v, err_v);
    chk(rd_v, e);
  endtask

  // Interval between two consecutive match pulses of one channel
  task gap(input int ch, output int n);
    int k;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while ((ch == 0 ? irq1 : irq2) !== 1'b1 && k < 10000);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((ch == 0 ? irq1 : irq2) !== 1'b1 && n < 10000);
  endtask

  task tally_and_finish;
    $display("Checks %0d, errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(ra[i], rv[i]);
    chk({28'h0, irq2, irq1, wave2, wave1}, 32'h0);
    apb(1'b0, 8'h40, 32'h0, rd_v, err_v);
    chk({31'h0, err_v}, 32'h1);
    chk(rd_v, 32'h0);
    // Event counting: ch1 rising, ch2 falling; output control set while stopped
    wr(ADDR_CLK_SEL, 32'h10);
    wr(ADDR_CMP_ONE, 32'h2);
    wr(ADDR_CMP_TWO, 32'h1);
    wr(ADDR_OUT_CTRL, 32'h11);
    wr(ADDR_RUN, 32'h3);
    event_source_i.pulse(1, 2, 3);
    rd(ADDR_CNT_ONE, 32'h2);
    rd(ADDR_CNT_TWO, 32'h0);
    event_source_i.pulse(2, 1, 2);
    rd(ADDR_CNT_TWO, 32'h1);
    event_source_i.pulse(1, 1, 3);
    rd(ADDR_CNT_ONE, 32'h0);
    chk(32'(n_irq1), 32'h1);
    chk({31'h0, wave1}, 32'h1);
    event_source_i.pulse(1, 1, 4);
    rd(ADDR_CNT_ONE, 32'h1);
    event_source_i.pulse(2, 1, 2);
    // Sync, match and wave pin flop take four edges after the pulse ends
    repeat (4) @(posedge pclk);
    chk(32'(n_irq2), 32'h1);
    chk({31'h0, wave2}, 32'h1);
    // Force strobes act on the output and read back as zero
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_OUT_CTRL, 32'h15);
    repeat (2) @(posedge pclk);
    chk({31'h0, wave1}, 32'h0);
    rd(ADDR_OUT_CTRL, 32'h11);
    wr(ADDR_OUT_CTRL, 32'h19);
    repeat (2) @(posedge pclk);
    chk({31'h0, wave1}, 32'h1);
    // Prohibited code leaves ch2 idle
    wr(ADDR_CLK_SEL, 32'h20);
    wr(ADDR_CMP_TWO, 32'hFF);
    wr(ADDR_RUN, 32'h2);
    event_source_i.pulse(2, 2, 2);
    rd(ADDR_CNT_TWO, 32'h0);
    // Full 8-bit range on the finest internal clock
    wr(ADDR_RUN, 32'h0);
    wr(ADDR_CLK_SEL, 32'h6);
    wr(ADDR_OSC_MODE, 32'h1);
    wr(ADDR_CMP_ONE, 32'hFF);
    wr(ADDR_RUN, 32'h1);
    gap(0, gap_n);
    chk(32'(gap_n), 32'd512);
    // Every internal ch2 code in both oscillation modes
    for (int osc = 0; osc < 2; osc++) begin
      for (int c = 6; c < 16; c++) begin
        wr(ADDR_RUN, 32'h0);
        wr(ADDR_CLK_SEL, 32'(c << 4));
        wr(ADDR_OSC_MODE, 32'(osc));
        wr(ADDR_CMP_TWO, 32'h0);
        wr(ADDR_RUN, 32'h2);
        gap(1, gap_n);
        expv = ((c == 15) ? 2048 : (1 << (c - 5))) * ((osc == 1) ? 1 : 2);
        chk(32'(gap_n), 32'(expv));
      end
    end
    // Slow source, then a reset in mid-run
    wr(ADDR_CMP_ONE, 32'hFF);
    wr(ADDR_RUN, 32'h1);
    event_source_i.pulse(1, 3, 5);
    rd(ADDR_CNT_ONE, 32'h3);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({28'h0, irq2, irq1, wave2, wave1}, 32'h0);
    presetn <= 1'b1;
    rd(ADDR_CNT_ONE, 32'h0);
    tally_and_finish;
  end
endmodule
